// ---- xrt_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module xrt_core #(
  parameter int DEPTH = xrt_pkg::MEM_DEPTH
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire xrt_pkg::xrt_cmd_e             cmd,
  input  wire logic                          cmd_valid,
  input  wire logic [xrt_pkg::ADDR_W-1:0]    oper_addr,
  input  wire logic [xrt_pkg::OPC_W-1:0]     opcode,
  input  wire logic [xrt_pkg::SHIFT_W-1:0]   shift_count,
  input  wire logic [5:0]                    field_lo,
  input  wire logic [5:0]                    field_hi,
  input  wire logic                          repeat_active,
  input  wire logic                          repeat_end,
  input  wire logic                          jump_valid,
  input  wire logic [xrt_pkg::ADDR_W-1:0]    jump_addr,
  input  wire logic                          intr_req,
  input  wire logic [xrt_pkg::NARROW_W-1:0]  narrow_in,
  input  wire logic                          narrow_in_load,
  input  wire logic [xrt_pkg::WORD_W-1:0]    wide_in,
  input  wire logic                          wide_in_load,
  input  wire logic [xrt_pkg::ACC_W-1:0]     acc_in,
  input  wire logic                          acc_in_load,
  output logic      [xrt_pkg::WORD_W-1:0]    exch_word,
  output logic      [xrt_pkg::WORD_W-1:0]    instruction_hold_register,
  output logic      [xrt_pkg::ADDR_W-1:0]    program_address_counter,
  output logic      [xrt_pkg::NARROW_W-1:0]  narrow_io_buffer,
  output logic      [xrt_pkg::WORD_W-1:0]    wide_io_buffer,
  output logic      [xrt_pkg::WORD_W-1:0]    aux_shift_reg,
  output logic      [xrt_pkg::ACC_W-1:0]     accumulator,
  output logic                               busy,
  output logic                               done,
  output logic                               store_refused
);
  import xrt_pkg::*;

  // ---------------------------------------------------------------------------
  // State and storage connections.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {XRT_IDLE, XRT_FT_HOLD, XRT_IT_HOLD} xrt_state_e;

  xrt_mem_if mem ();

  xrt_state_e        state_ff;
  logic [WORD_W-1:0] x_ff;
  logic [WORD_W-1:0] hold_ff;
  logic [ADDR_W-1:0] pac_ff;
  logic [NARROW_W-1:0] nbuf_ff;
  logic [WORD_W-1:0] wbuf_ff;
  logic [WORD_W-1:0] aux_ff;
  logic [ACC_W-1:0]  acc_ff;
  logic              intr_pend_ff;
  logic              done_ff;
  logic              refused_ff;
  logic              busy_ff;
  logic [ACC_W-1:0]  acc_sum;
  logic [WORD_W-1:0] field_mask;
  logic [WORD_W-1:0] oper_word;
  logic              is_acc;
  logic              is_aux;
  logic              acc_ok;
  logic              go;
  logic              fetch_run;

  xrt_storage #(
    .DEPTH   (DEPTH)
  ) u_store (
    .sys_clk (sys_clk),
    .mem     (mem)
  );

  xrt_adder u_add (
    .acc  ('0),
    .oper ({{(ACC_W-WORD_W){x_ff[WORD_W-1]}}, x_ff}),
    .sum  (acc_sum)
  );

  // ---------------------------------------------------------------------------
  // Address decode and operand selection.
  // ---------------------------------------------------------------------------
  assign go        = cmd_valid && (state_ff == XRT_IDLE);
  assign is_acc    = (oper_addr == ACC_ADDR);
  assign is_aux    = (oper_addr == AUX_ADDR);
  // Repeat itself and mid-repeat steps skip the fetch.
  assign fetch_run = go && (cmd == XRT_FETCH) &&
                     (!repeat_active || repeat_end);
  assign acc_ok    = (opcode == OPC_TP) || (opcode == OPC_TM) ||
                     (opcode == OPC_TN) || (opcode == OPC_LT) ||
                     (opcode == OPC_55) || (opcode == OPC_73) ||
                     (opcode == OPC_ER);

  // Operand source; the accumulator yields its right half.
  always_comb begin
    if (is_acc) begin
      oper_word = acc_ff[WORD_W-1:0];
    end else if (is_aux) begin
      oper_word = aux_ff;
    end else begin
      oper_word = mem.rdata;
    end
  end

  // Field mask spanning stages field_lo through field_hi.
  always_comb begin
    for (int i = 0; i < WORD_W; i++) begin
      field_mask[i] = (i >= int'(field_lo)) && (i <= int'(field_hi));
    end
  end

  // ---------------------------------------------------------------------------
  // Storage port drive.
  // ---------------------------------------------------------------------------
  always_comb begin
    mem.addr  = oper_addr;
    mem.wdata = x_ff;
    mem.wmask = '1;
    mem.we    = 1'b0;
    if (state_ff == XRT_IDLE && fetch_run) begin
      mem.addr = (intr_pend_ff || intr_req) ? INTR_CELL_ADDR :
                 (jump_valid ? jump_addr : pac_ff);
    end else if (go) begin
      case (cmd)
        XRT_ST_OPER: begin
          mem.we = !is_acc && !is_aux;
        end
        XRT_ST_FIELD: begin
          mem.wmask = field_mask;
          mem.we    = !is_acc && !is_aux;
        end
        XRT_ST_LINK: begin
          mem.addr  = LINK_CELL_ADDR;
          mem.wmask = {{(WORD_W-ADDR_W){1'b0}}, {ADDR_W{1'b1}}};
          mem.we    = 1'b1;
        end
        default: begin
          mem.we = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer of the fetch and interrupt termination.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= XRT_IDLE;
    end else begin
      case (state_ff)
        XRT_IDLE: begin
          if (fetch_run) begin
            state_ff <= (intr_pend_ff || intr_req) ? XRT_IT_HOLD
                                                   : XRT_FT_HOLD;
          end
        end
        XRT_FT_HOLD: state_ff <= XRT_IDLE;
        XRT_IT_HOLD: state_ff <= XRT_IDLE;
        default:     state_ff <= XRT_IDLE;
      endcase
    end
  end

  // Busy covers the single hold step, so the pin comes from a flop.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= fetch_run;
    end
  end

  // Interrupt stays pending until a termination takes it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      intr_pend_ff <= 1'b0;
    end else if (state_ff == XRT_IT_HOLD) begin
      intr_pend_ff <= intr_req;
    end else if (intr_req) begin
      intr_pend_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Exchange register. Sources are only read, never altered.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      x_ff <= '0;
    end else if (fetch_run) begin
      x_ff <= mem.rdata;
    end else if (go) begin
      case (cmd)
        XRT_LD_ADDR:   x_ff[ADDR_W-1:0]   <= oper_addr;
        XRT_LD_SHIFT:  x_ff[SHIFT_W-1:0]  <= shift_count;
        XRT_LD_NARROW: x_ff[NARROW_W-1:0] <= nbuf_ff;
        XRT_LD_WIDE:   x_ff <= wbuf_ff;
        XRT_LD_OPER:   x_ff <= oper_word;
        default:       x_ff <= x_ff;
      endcase
    end
  end

  // Program address counter: advance on fetch, no advance on interrupt.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pac_ff <= '0;
    end else if (fetch_run) begin
      if (intr_pend_ff || intr_req) begin
        pac_ff <= jump_valid ? jump_addr : pac_ff;
      end else begin
        pac_ff <= (jump_valid ? jump_addr : pac_ff) + 15'h0001;
      end
    end
  end

  // Hold register takes the exchange word in the second fetch step.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_ff <= '0;
    end else if (state_ff == XRT_FT_HOLD || state_ff == XRT_IT_HOLD) begin
      hold_ff <= x_ff;
    end else if (go && cmd == XRT_ST_HOLD) begin
      hold_ff <= x_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // I/O buffers, auxiliary register and accumulator.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nbuf_ff <= '0;
    end else if (go && cmd == XRT_ST_NARROW) begin
      nbuf_ff <= x_ff[NARROW_W-1:0];
    end else if (narrow_in_load) begin
      nbuf_ff <= narrow_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wbuf_ff <= '0;
    end else if (go && cmd == XRT_ST_WIDE) begin
      wbuf_ff <= x_ff;
    end else if (wide_in_load) begin
      wbuf_ff <= wide_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_ff <= '0;
    end else if (go && cmd == XRT_ST_OPER && is_aux) begin
      aux_ff <= x_ff;
    end
  end

  // Accumulator store is a clear then add of the exchange word.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (go && cmd == XRT_ST_OPER && is_acc && acc_ok) begin
      acc_ff <= acc_sum;
    end else if (acc_in_load) begin
      acc_ff <= acc_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Status outputs.
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      done_ff    <= (go && cmd != XRT_FETCH) ||
                    (go && cmd == XRT_FETCH && !fetch_run) ||
                    state_ff == XRT_FT_HOLD || state_ff == XRT_IT_HOLD;
      refused_ff <= go && (((cmd == XRT_ST_OPER) && is_acc && !acc_ok) ||
                    ((cmd == XRT_ST_FIELD) && (is_acc || is_aux)));
    end
  end

  assign exch_word                 = x_ff;
  assign instruction_hold_register = hold_ff;
  assign program_address_counter   = pac_ff;
  assign narrow_io_buffer          = nbuf_ff;
  assign wide_io_buffer            = wbuf_ff;
  assign aux_shift_reg             = aux_ff;
  assign accumulator               = acc_ff;
  assign busy                      = busy_ff;
  assign done                      = done_ff;
  assign store_refused             = refused_ff;
endmodule
`default_nettype wire

// ---- xrt_pkg.sv ----
package xrt_pkg;
  // ---------------------------------------------------------------------------
  // Word and address layout.
  // ---------------------------------------------------------------------------
  localparam int WORD_W       = 36;
  localparam int ADDR_W       = 15;
  localparam int NARROW_W     = 8;
  localparam int SHIFT_W      = 7;
  localparam int ACC_W        = 72;
  localparam int OPC_W        = 6;
  localparam int OPC_LSB      = 30;
  localparam int MEM_DEPTH    = 4096;

  // ---------------------------------------------------------------------------
  // Fixed storage locations.
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LINK_CELL_ADDR  = 15'h0000;
  localparam logic [ADDR_W-1:0] LINK_DRUM_ADDR  = 15'h4001;
  localparam logic [ADDR_W-1:0] INTR_CELL_ADDR  = 15'h0002;
  localparam logic [ADDR_W-1:0] DRUM_BASE_ADDR  = 15'h4000;
  localparam logic [ADDR_W-1:0] AUX_ADDR        = 15'h7ffe;
  localparam logic [ADDR_W-1:0] ACC_ADDR        = 15'h7fff;

  // ---------------------------------------------------------------------------
  // Opcodes (octal 11,12,13,22,55,73,76) that may load the accumulator.
  // ---------------------------------------------------------------------------
  localparam logic [OPC_W-1:0] OPC_TP = 6'h09;
  localparam logic [OPC_W-1:0] OPC_TM = 6'h0a;
  localparam logic [OPC_W-1:0] OPC_TN = 6'h0b;
  localparam logic [OPC_W-1:0] OPC_LT = 6'h12;
  localparam logic [OPC_W-1:0] OPC_55 = 6'h2d;
  localparam logic [OPC_W-1:0] OPC_73 = 6'h3b;
  localparam logic [OPC_W-1:0] OPC_ER = 6'h3e;

  // ---------------------------------------------------------------------------
  // Transfer commands of the exchange register.
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    XRT_NOP, XRT_LD_ADDR, XRT_LD_SHIFT, XRT_LD_NARROW, XRT_LD_WIDE,
    XRT_LD_OPER, XRT_ST_NARROW, XRT_ST_WIDE, XRT_ST_HOLD, XRT_ST_OPER,
    XRT_ST_FIELD, XRT_ST_LINK, XRT_FETCH
  } xrt_cmd_e;
endpackage

// ---- xrt_mem_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Storage port between the sequencer and the storage array.
interface xrt_mem_if;
  import xrt_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] wmask;
  logic              we;
  logic [WORD_W-1:0] rdata;
  modport master (output addr, output wdata, output wmask, output we,
                  input rdata);
  modport slave  (input addr, input wdata, input wmask, input we,
                  output rdata);
endinterface
`default_nettype wire

// ---- xrt_storage.sv ----
`timescale 1ns/10ps
`default_nettype none
module xrt_storage #(
  parameter int DEPTH = xrt_pkg::MEM_DEPTH
) (
  input  wire logic   sys_clk,
  xrt_mem_if.slave    mem
);
  import xrt_pkg::*;

  // ---------------------------------------------------------------------------
  // Core and drum storage array.
  // ---------------------------------------------------------------------------
  logic [WORD_W-1:0] store_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] idx;

  // Drum address 40001 aliases core cell 00000; others fold by depth.
  always_comb begin
    if (mem.addr == LINK_DRUM_ADDR) begin
      idx = '0;
    end else begin
      idx = mem.addr[$clog2(DEPTH)-1:0];
    end
  end

  // Masked write keeps untouched stages; read is combinational.
  always_ff @(posedge sys_clk) begin
    if (mem.we) begin
      store_ff[idx] <= (store_ff[idx] & ~mem.wmask) | (mem.wdata & mem.wmask);
    end
  end

  assign mem.rdata = store_ff[idx];
endmodule
`default_nettype wire

// ---- xrt_adder.sv ----
`timescale 1ns/10ps
`default_nettype none
module xrt_adder (
  input  wire logic [xrt_pkg::ACC_W-1:0] acc,
  input  wire logic [xrt_pkg::ACC_W-1:0] oper,
  output logic      [xrt_pkg::ACC_W-1:0] sum
);
  import xrt_pkg::*;

  // ---------------------------------------------------------------------------
  // Ones-complement add done as subtraction of the complement.
  // ---------------------------------------------------------------------------
  logic [ACC_W:0] diff;

  // Subtract with end-around borrow.
  always_comb begin
    diff = {1'b0, acc} - {1'b0, ~oper};
    if (diff[ACC_W]) begin
      sum = diff[ACC_W-1:0] - {{(ACC_W-1){1'b0}}, 1'b1};
    end else begin
      sum = diff[ACC_W-1:0];
    end
  end
endmodule
`default_nettype wire

// ---- xrt_core_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module xrt_core_assertions
  import xrt_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire xrt_cmd_e          cmd,
  input wire logic              cmd_valid,
  input wire logic [ADDR_W-1:0] oper_addr,
  input wire logic [OPC_W-1:0]  opcode,
  input wire logic              repeat_active,
  input wire logic              repeat_end,
  input wire logic              jump_valid,
  input wire logic [ADDR_W-1:0] jump_addr,
  input wire logic              intr_req,
  input wire logic              acc_in_load,
  input wire logic              wide_in_load,
  input wire logic [WORD_W-1:0] exch_word,
  input wire logic [WORD_W-1:0] instruction_hold_register,
  input wire logic [ADDR_W-1:0] program_address_counter,
  input wire logic [7:0]        narrow_io_buffer,
  input wire logic [WORD_W-1:0] wide_io_buffer,
  input wire logic [WORD_W-1:0] aux_shift_reg,
  input wire logic [ACC_W-1:0]  accumulator,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              store_refused
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // -------------------------------------------------------------------------
  // Helper logic.
  // -------------------------------------------------------------------------
  // A request is taken when valid meets an idle sequencer.
  logic take;
  logic acc_ok;
  logic fetch;
  logic pend_ff;
  assign take   = cmd_valid && !busy;
  assign fetch  = take && cmd == XRT_FETCH && !repeat_active && !intr_req;
  assign acc_ok = opcode inside {OPC_TP, OPC_TM, OPC_TN, OPC_LT, OPC_55,
                                 OPC_73, OPC_ER};

  // Tracks an interrupt waiting for the next fetch to terminate with.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (intr_req) begin
      pend_ff <= 1'b1;
    end else if (fetch) begin
      pend_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------------------
  a_addr_low: assert property (
    take && cmd == XRT_LD_ADDR |=> exch_word ==
    {$past(exch_word[35:15]), $past(oper_addr)})
    else $error("Address load touched the wrong stages.");
  a_wide_store: assert property (
    take && cmd == XRT_ST_WIDE && !wide_in_load |=>
    wide_io_buffer == $past(exch_word) && $stable(exch_word))
    else $error("Wide buffer store is wrong.");
  a_fetch_hold: assert property (
    take && cmd == XRT_FETCH && !repeat_active |=> busy ##1
    (!busy && done && instruction_hold_register == exch_word))
    else $error("Fetch did not reach the hold register in time.");
  a_fetch_count: assert property (
    fetch && !jump_valid && !pend_ff |=> program_address_counter ==
    $past(program_address_counter) + 15'h1)
    else $error("Counter did not advance by one.");
  a_fetch_jump: assert property (
    fetch && jump_valid && !pend_ff |=>
    program_address_counter == $past(jump_addr) + 15'h1)
    else $error("Fetch ignored the jump address.");
  a_intr_keep: assert property (
    fetch && !jump_valid && pend_ff |=> $stable(program_address_counter))
    else $error("Interrupt termination moved the counter.");
  a_repeat_skip: assert property (
    take && cmd == XRT_FETCH && repeat_active && !repeat_end |=>
    $stable(program_address_counter) && $stable(instruction_hold_register))
    else $error("Fetch under repeat control was not skipped.");
  a_acc_refuse: assert property (
    take && cmd == XRT_ST_OPER && oper_addr == ACC_ADDR && !acc_ok &&
    !acc_in_load |=> $stable(accumulator) ##[0:1] store_refused)
    else $error("Accumulator store was not suppressed.");
  a_acc_clear_add: assert property (
    take && cmd == XRT_ST_OPER && oper_addr == ACC_ADDR && acc_ok &&
    exch_word != {WORD_W{1'b1}} && !acc_in_load |=> accumulator ==
    {{36{$past(exch_word[35])}}, $past(exch_word)})
    else $error("Accumulator clear and add is wrong.");
  a_field_aux: assert property (
    take && cmd == XRT_ST_FIELD && oper_addr == AUX_ADDR |=>
    $stable(aux_shift_reg) ##[0:1] store_refused)
    else $error("Partial store into the auxiliary register.");

  c_intr_fetch: cover property (fetch && pend_ff);
  c_refused: cover property (store_refused);
  c_link: cover property (take && cmd == XRT_ST_LINK);
endmodule

bind xrt_core xrt_core_assertions u_chk (
  .sys_clk, .rst, .cmd, .cmd_valid, .oper_addr, .opcode, .repeat_active,
  .repeat_end, .jump_valid, .jump_addr, .intr_req, .acc_in_load,
  .wide_in_load, .exch_word, .instruction_hold_register,
  .program_address_counter, .narrow_io_buffer, .wide_io_buffer,
  .aux_shift_reg, .accumulator, .busy, .done, .store_refused
);
`default_nettype wire

// ---- test_exchange_register_transfer_fetch.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_exchange_register_transfer_fetch;
  import xrt_pkg::*;
  xrt_cmd_e    cmd;
  logic        sys_clk, rst, cmd_valid, repeat_active, repeat_end;
  logic        jump_valid, intr_req, narrow_in_load, wide_in_load;
  logic        acc_in_load, busy, done, refused, seen_ref;
  logic [14:0] oper_addr, jump_addr, pc;
  logic [5:0]  opcode, field_lo, field_hi;
  logic [6:0]  shift_count;
  logic [7:0]  narrow_in, nb;
  logic [35:0] wide_in, xw, hold, wb, aux;
  logic [71:0] acc_in, acc;
  int          num_errors, checked;

  xrt_core #(.DEPTH(64)) dut (
    .sys_clk, .rst, .cmd, .cmd_valid, .oper_addr, .opcode, .shift_count,
    .field_lo, .field_hi, .repeat_active, .repeat_end, .jump_valid,
    .jump_addr, .intr_req, .narrow_in, .narrow_in_load, .wide_in,
    .wide_in_load, .acc_in, .acc_in_load, .exch_word(xw),
    .instruction_hold_register(hold), .program_address_counter(pc),
    .narrow_io_buffer(nb), .wide_io_buffer(wb), .aux_shift_reg(aux),
    .accumulator(acc), .busy, .done, .store_refused(refused)
  );

  // Free-running 200 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Issues one command and waits a bounded time for its completion.
  task automatic run(input xrt_cmd_e c, input logic [14:0] a);
    int   k;
    logic got;
    @(negedge sys_clk);
    cmd = c;
    oper_addr = a;
    cmd_valid = 1'b1;
    got = 1'b0;
    seen_ref = 1'b0;
    for (k = 0; k < 6 && !got; k++) begin
      @(posedge sys_clk);
      #1;
      got = (done === 1'b1);
      seen_ref = seen_ref | (refused === 1'b1);
      if (k == 0) begin
        @(negedge sys_clk);
        cmd_valid = 1'b0;
      end
    end
    check({71'h0, got}, 72'h1);
  endtask

  // Loads the exchange register through the wide buffer.
  task automatic set_x(input logic [35:0] v);
    @(negedge sys_clk);
    wide_in = v;
    wide_in_load = 1'b1;
    @(negedge sys_clk);
    wide_in_load = 1'b0;
    run(XRT_LD_WIDE, 15'h0);
  endtask

  // Writes one storage word.
  task automatic put(input logic [14:0] a, input logic [35:0] v);
    set_x(v);
    run(XRT_ST_OPER, a);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------
  // Partial and full loads, then buffer stores from the exchange word.
  task automatic t_loads;
    set_x(36'hf_ffff_ffff);
    check(xw, 36'hf_ffff_ffff);
    run(XRT_LD_ADDR, 15'h1234);
    check(xw, 36'hf_ffff_9234);
    run(XRT_LD_NARROW, 15'h0);
    check(xw, 36'hf_ffff_92a5);
    run(XRT_LD_ADDR, 15'h003c);
    run(XRT_ST_NARROW, 15'h0);
    check(nb, 8'h3c);
    check(xw, 36'hf_ffff_803c);
    run(XRT_ST_WIDE, 15'h0);
    check(wb, 36'hf_ffff_803c);
    run(XRT_LD_SHIFT, 15'h0);
    check(xw[6:0], 7'h55);
    run(XRT_ST_HOLD, 15'h0);
    check(hold, 36'hf_ffff_8055);
    check(xw, 36'hf_ffff_8055);
  endtask

  // Jump fetch, plain fetch, operand reads from storage and aux.
  task automatic t_fetch;
    put(15'h10, 36'h1_2345_6789);
    put(15'h11, 36'h9_8765_4321);
    @(negedge sys_clk);
    jump_valid = 1'b1;
    run(XRT_FETCH, 15'h0);
    check(xw, 36'h1_2345_6789);
    check(hold, 36'h1_2345_6789);
    check(pc, 15'h11);
    @(negedge sys_clk);
    jump_valid = 1'b0;
    run(XRT_FETCH, 15'h0);
    check(hold, 36'h9_8765_4321);
    check(pc, 15'h12);
    run(XRT_LD_OPER, 15'h10);
    check(xw, 36'h1_2345_6789);
    run(XRT_ST_OPER, AUX_ADDR);
    set_x(36'h0);
    run(XRT_LD_OPER, AUX_ADDR);
    check(xw, 36'h1_2345_6789);
  endtask

  // Accumulator reads, allowed clear-add stores and a refused store.
  task automatic t_acc;
    logic [5:0]  ops [7] = '{OPC_TP, OPC_TM, OPC_TN, OPC_LT, OPC_55,
                             OPC_73, OPC_ER};
    logic [35:0] v;
    @(negedge sys_clk);
    acc_in = {36'ha_aaaa_aaaa, 36'h1_2345_6789};
    acc_in_load = 1'b1;
    @(negedge sys_clk);
    acc_in_load = 1'b0;
    run(XRT_LD_OPER, ACC_ADDR);
    check(xw, 36'h1_2345_6789);
    for (int i = 0; i < 7; i++) begin
      v = ((i % 2) != 0) ? 36'h8_0000_0010 : 36'h0_1234_5670;
      v[3:0] = 4'(i);
      @(negedge sys_clk);
      opcode = ops[i];
      set_x(v);
      run(XRT_ST_OPER, ACC_ADDR);
      check(acc, {{36{v[35]}}, v});
    end
    @(negedge sys_clk);
    opcode = 6'h10;
    set_x(36'h0_5555_5555);
    run(XRT_ST_OPER, ACC_ADDR);
    check(acc, {36'h0, 36'h0_1234_5676});
    check({71'h0, seen_ref}, 72'h1);
  endtask

  // Field store into storage, refused field store into aux, link store.
  task automatic t_field_link;
    put(15'h20, 36'h0);
    set_x(36'hf_ffff_ffff);
    run(XRT_ST_FIELD, 15'h20);
    run(XRT_LD_OPER, 15'h20);
    check(xw, 36'h0_0000_0ff0);
    run(XRT_ST_FIELD, AUX_ADDR);
    check(aux, 36'h1_2345_6789);
    check({71'h0, seen_ref}, 72'h1);
    put(LINK_CELL_ADDR, 36'hf_ffff_ffff);
    set_x(36'h0_0000_2abc);
    run(XRT_ST_LINK, 15'h0);
    run(XRT_LD_OPER, LINK_DRUM_ADDR);
    check(xw, 36'hf_ffff_aabc);
  endtask

  // Repeat control gating, then an interrupt termination.
  task automatic t_repeat_intr;
    put(15'h12, 36'h2_7182_8182);
    put(15'h13, 36'h1_4142_1356);
    @(negedge sys_clk);
    repeat_active = 1'b1;
    run(XRT_FETCH, 15'h0);
    check(pc, 15'h12);
    check(hold, 36'h9_8765_4321);
    @(negedge sys_clk);
    repeat_end = 1'b1;
    run(XRT_FETCH, 15'h0);
    check(pc, 15'h13);
    check(hold, 36'h2_7182_8182);
    @(negedge sys_clk);
    repeat_active = 1'b0;
    repeat_end = 1'b0;
    put(INTR_CELL_ADDR, 36'h3_1415_9265);
    @(negedge sys_clk);
    intr_req = 1'b1;
    @(negedge sys_clk);
    intr_req = 1'b0;
    run(XRT_FETCH, 15'h0);
    check(hold, 36'h3_1415_9265);
    check(pc, 15'h13);
    run(XRT_FETCH, 15'h0);
    check(pc, 15'h14);
    check(hold, 36'h1_4142_1356);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run length.
  initial begin
    #20000;
    num_errors++;
    $display("BAD at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    {cmd_valid, repeat_active, repeat_end, jump_valid, intr_req} = '0;
    {narrow_in_load, wide_in_load, acc_in_load, seen_ref} = '0;
    cmd = XRT_NOP;
    oper_addr = 15'h0;
    jump_addr = 15'h10;
    opcode = 6'h0;
    field_lo = 6'h04;
    field_hi = 6'h0b;
    shift_count = 7'h55;
    narrow_in = 8'ha5;
    wide_in = 36'h0;
    acc_in = 72'h0;
    num_errors = 0;
    checked = 0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    narrow_in_load = 1'b1;
    @(negedge sys_clk);
    narrow_in_load = 1'b0;
    t_loads();
    t_fetch();
    t_acc();
    t_field_link();
    t_repeat_intr();
    tally_and_finish();
  end
endmodule
`default_nettype wire
